// [rtl/hpo_host_port.sv]
// Host port: APB control, parallel bus handshake, serial link, interrupt and loopback pins
`timescale 1ns/1ns
//
// Contract
// - During a serial write the serial data output stays undriven throughout.
// - During a serial read the output floats for the command byte, then drives.
// - Edge select high shifts out on falling clock edges, low on rising edges.
// - Intel mode: ready high lets the cycle end, low forces host wait states.
// - Motorola mode: acknowledge low marks valid read data or accepted write data.
// - Interrupt is active low open drain, pulled low only while something is pending.
// - Exactly four interrupt sources share the single interrupt output.
// - Hardware mode loopback select: low remote, mid none, high analog loopback.
// - Non-multiplexed mode uses the eight shared lines as a plain data bus.
// - Multiplexed mode carries address first, then data, on the same lines.
// - Serial input is sampled on rising shift clock edges.
// - Motorola write data taken at strobe rise; read data driven when direction high.
module hpo_host_port import hpo_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk,
    input wire logic serial_cs_n,
    input wire logic serial_data_in,
    input wire logic output_edge_select,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic host_cs_n,
    input wire logic host_strobe_n,
    input wire logic host_dir,
    input wire logic host_ale,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] data_bus_line_in,
    output logic [7:0] data_bus_line_out,
    output logic data_bus_line_oe,
    output logic ready_ack,
    input wire logic [HPO_NIRQ-1:0] irq_src,
    output logic interrupt_n_out,
    output logic interrupt_n_oe,
    input wire logic [HPO_NCH-1:0] loopback_select_lo,
    input wire logic [HPO_NCH-1:0] loopback_select_hi,
    output logic [2*HPO_NCH-1:0] loopback_mode
);
    typedef struct packed {
        logic [HPO_PW-1:0] s1;
        logic [HPO_PW-1:0] s2;
        logic [HPO_PW-1:0] s3;
        logic [HPO_PW-1:0] pin;
        logic [1:0] mode;
        logic muxed;
        logic hw;
        logic [7:0] srd;
        logic [7:0] lpcfg;
        logic [2*HPO_NCH-1:0] lpst;
        logic [HPO_NREG-1:0][7:0] hreg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        hpo_hst_t hst;
        logic [4:0] haddr;
        logic rdy_ack;
        logic [7:0] dout;
        logic doe;
        logic [7:0] wdata;
        logic ale_q;
        logic tog_seen;
        logic [7:0] ser_wcnt;
        hpo_ser_word_t ser_last;
        logic int_oe;
    } hpo_top_t;

    hpo_top_t st;
    hpo_top_t next;
    hpo_par_pins_t p;
    hpo_ser_word_t ser_word;
    logic ser_tog;
    logic [HPO_PW-1:0] raw;
    logic moto;
    logic host_en;
    logic rd_act;
    logic wr_act;
    logic [31:0] apb_rd;
    logic apb_hit;

    // Per-bit filter: a change counts once the second and third stages agree
    function automatic logic [HPO_PW-1:0] hpo_agree(input logic [HPO_PW-1:0] s2,
            input logic [HPO_PW-1:0] s3, input logic [HPO_PW-1:0] prev);
        hpo_agree = (s3 & ~(s2 ^ s3)) | (prev & (s2 ^ s3));
    endfunction : hpo_agree

    // Host register lookup; unimplemented addresses read as zero
    function automatic logic [7:0] hpo_hread(input logic [HPO_NREG-1:0][7:0] regs,
            input logic [4:0] a);
        hpo_hread = (a < 5'(HPO_NREG)) ? regs[a[1:0]] : 8'h00;
    endfunction : hpo_hread

    hpo_serial_link u_link (
        .sclk(sclk),
        .presetn(presetn),
        .frame_n(serial_cs_n),
        .serial_data_in(serial_data_in),
        .output_edge_select(output_edge_select),
        .rd_data(st.srd),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe),
        .wr_word(ser_word),
        .wr_toggle(ser_tog)
    );

    assign raw = {host_cs_n, host_strobe_n, host_dir, host_ale, host_addr, data_bus_line_in,
                  loopback_select_hi, loopback_select_lo, ser_tog};
    assign p = hpo_par_pins_t'(st.pin[HPO_PW-1:HPO_PAR_LSB]);
    assign moto = (st.mode == HPO_MODE_MOTO);
    // Hardware and serial modes keep the parallel port idle so the bus stays released
    assign host_en = !st.hw && (st.mode == HPO_MODE_INTEL || moto) && !p.cs_n;
    assign rd_act = host_en && !p.strobe_n && (!moto || p.dir);
    assign wr_act = host_en && (moto ? (!p.strobe_n && !p.dir) : !p.dir);

    always_comb begin
        apb_hit = 1'b1;
        apb_rd = 32'h0000_0000;
        if (paddr[7:4] == HPO_HREG_PAGE) begin
            apb_rd = {24'h00_0000, st.hreg[paddr[3:2]]};
        end else begin
            case (paddr)
                HPO_CTRL_OFF: apb_rd = {28'h000_0000, st.hw, st.muxed, st.mode};
                HPO_SRD_OFF: apb_rd = {24'h00_0000, st.srd};
                HPO_STAT_OFF: apb_rd = {7'h00, st.ser_last, st.ser_wcnt, irq_src};
                HPO_LPCFG_OFF: apb_rd = {24'h00_0000, st.lpcfg};
                HPO_LPST_OFF: apb_rd = {24'h00_0000, st.lpst};
                default: apb_hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        next = st;
        next.s1 = raw;
        next.s2 = st.s1;
        next.s3 = st.s2;
        next.pin = hpo_agree(st.s2, st.s3, st.pin);

        // APB: one wait state, write lands on the edge that completes the access
        if (psel && penable && !st.pready) begin
            next.pready = 1'b1;
            next.prdata = apb_rd;
            next.pslverr = !apb_hit;
        end else if (psel && penable) begin
            next.pready = 1'b0;
            next.pslverr = 1'b0;
            if (pwrite && apb_hit) begin
                if (paddr[7:4] == HPO_HREG_PAGE) begin
                    next.hreg[paddr[3:2]] = pwdata[7:0];
                end else begin
                    case (paddr)
                        HPO_CTRL_OFF: begin
                            next.mode = pwdata[HPO_CTRL_MODE_LSB +: 2];
                            next.muxed = pwdata[HPO_CTRL_MUX_BIT];
                            next.hw = pwdata[HPO_CTRL_HW_BIT];
                        end
                        HPO_SRD_OFF: next.srd = pwdata[7:0];
                        HPO_LPCFG_OFF: next.lpcfg = pwdata[7:0];
                        default: next.srd = st.srd;
                    endcase
                end
            end
        end

        // Multiplexed bus: address is latched from the shared lines as ALE falls
        next.ale_q = p.ale;
        if (st.muxed && st.ale_q && !p.ale) begin
            next.haddr = p.data[4:0];
        end

        case (st.hst)
            HPO_H_IDLE: begin
                next.rdy_ack = 1'b1;
                next.doe = 1'b0;
                if (rd_act || wr_act) begin
                    if (!st.muxed) begin
                        next.haddr = p.addr;
                    end
                    next.rdy_ack = moto;
                    next.hst = rd_act ? HPO_H_RD_WAIT : HPO_H_WR_ACC;
                end
            end
            HPO_H_RD_WAIT: begin
                next.dout = hpo_hread(st.hreg, st.haddr);
                next.doe = 1'b1;
                next.rdy_ack = !moto;
                next.hst = HPO_H_RD_DRIVE;
            end
            HPO_H_RD_DRIVE: begin
                if (!rd_act) begin
                    next.doe = 1'b0;
                    next.rdy_ack = 1'b1;
                    next.hst = HPO_H_IDLE;
                end
            end
            HPO_H_WR_ACC: begin
                next.rdy_ack = !moto;
                if (wr_act) begin
                    next.wdata = p.data;
                end else begin
                    // Last value sampled while the write was active (strobe low in Motorola mode, direction low in Intel mode) is the one written
                    if (st.haddr < 5'(HPO_NREG)) begin
                        next.hreg[st.haddr[1:0]] = st.wdata;
                    end
                    next.rdy_ack = 1'b1;
                    next.hst = HPO_H_IDLE;
                end
            end
            default: next.hst = HPO_H_IDLE;
        endcase

        // Serial write words arrive by toggle; the word is stable long before it
        if (st.pin[0] != st.tog_seen) begin
            next.tog_seen = st.pin[0];
            next.ser_last = ser_word;
            next.ser_wcnt = st.ser_wcnt + 8'h01;
            if (ser_word.addr < 5'(HPO_NREG)) begin
                next.hreg[ser_word.addr[1:0]] = ser_word.data;
            end
        end

        for (int ch = 0; ch < HPO_NCH; ch++) begin
            if (!st.hw) begin
                next.lpst[2*ch +: 2] = st.lpcfg[2*ch +: 2];
            end else if (st.pin[HPO_LO_LSB + ch]) begin
                next.lpst[2*ch +: 2] = HPO_LB_REMOTE;
            end else if (st.pin[HPO_HI_LSB + ch]) begin
                next.lpst[2*ch +: 2] = HPO_LB_ANALOG;
            end else begin
                next.lpst[2*ch +: 2] = HPO_LB_NONE;
            end
        end

        next.int_oe = |irq_src;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.rdy_ack <= 1'b1;
            st.mode <= HPO_CTRL_RST[HPO_CTRL_MODE_LSB +: 2];
            st.muxed <= HPO_CTRL_RST[HPO_CTRL_MUX_BIT];
            st.hw <= HPO_CTRL_RST[HPO_CTRL_HW_BIT];
            st.lpcfg <= HPO_LPCFG_RST;
        end else begin
            st <= next;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign data_bus_line_out = st.dout;
    assign data_bus_line_oe = st.doe;
    assign ready_ack = st.rdy_ack;
    // Open drain: level is always low, only the enable moves
    assign interrupt_n_out = 1'b0;
    assign interrupt_n_oe = st.int_oe;
    assign loopback_mode = st.lpst;

    a_intel_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_IDLE && rd_act && !moto) |=> !ready_ack ##1 (ready_ack && data_bus_line_oe))
        else $error("intel ready did not hold one wait state");
    a_moto_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (moto && st.hst == HPO_H_RD_DRIVE) |-> (!ready_ack && data_bus_line_oe))
        else $error("acknowledge without valid read data");
    a_bus_release: assert property (@(posedge pclk) disable iff (!presetn)
        data_bus_line_oe |-> (st.hst == HPO_H_RD_DRIVE && $past(rd_act)))
        else $error("data bus driven outside a read");
    a_irq_pull: assert property (@(posedge pclk) disable iff (!presetn)
        (|irq_src) |=> (interrupt_n_oe && !interrupt_n_out))
        else $error("pending interrupt not pulled low");
    a_irq_float: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_src == 4'h0) |=> !interrupt_n_oe)
        else $error("interrupt driven with no source pending");
    a_loop_decode: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hw && st.pin[HPO_LO_LSB]) |=> loopback_mode[1:0] == HPO_LB_REMOTE)
        else $error("low loopback select not decoded as remote");
    a_moto_write: assert property (@(posedge pclk) disable iff (!presetn)
        (moto && st.hst == HPO_H_WR_ACC && !wr_act && st.haddr == 5'h00 && st.pin[0] == st.tog_seen)
        |=> st.hreg[0] == $past(st.wdata))
        else $error("write data not committed at strobe rise");
    a_mux_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (st.muxed && st.ale_q && !p.ale) |=> st.haddr == $past(p.data[4:0]))
        else $error("multiplexed address not latched");
    // Between accesses the handshake rests inactive, or a host would stall or misread
    a_intel_write: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_IDLE && wr_act && !rd_act && !moto)
        |=> !ready_ack ##1 ready_ack)
        else $error("intel write wait state wrong");
    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_IDLE && !rd_act && !wr_act)
        |=> ready_ack)
        else $error("ready low with no access");
    a_moto_wr_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (moto && st.hst == HPO_H_WR_ACC && $past(st.hst) == HPO_H_WR_ACC)
        |-> !ready_ack)
        else $error("write not acknowledged");
    a_moto_no_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (moto && st.hst == HPO_H_IDLE)
        |=> ready_ack)
        else $error("acknowledge before any data");
    a_lp_analog: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hw && !st.pin[HPO_LO_LSB] && st.pin[HPO_HI_LSB])
        |=> loopback_mode[1:0] == HPO_LB_ANALOG)
        else $error("high loopback select not decoded as analog");
    a_lp_none: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hw && !st.pin[HPO_LO_LSB] && !st.pin[HPO_HI_LSB])
        |=> loopback_mode[1:0] == HPO_LB_NONE)
        else $error("mid loopback select not decoded as none");
    a_nonmux_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.muxed && st.hst == HPO_H_IDLE && (rd_act || wr_act))
        |=> st.haddr == $past(p.addr))
        else $error("address pins not taken at access start");
    a_mux_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st.muxed && !(st.ale_q && !p.ale))
        |=> st.haddr == $past(st.haddr))
        else $error("multiplexed address moved without latch enable");
    a_read_release: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_RD_DRIVE && !rd_act)
        |=> (!data_bus_line_oe && ready_ack))
        else $error("bus not released after read");
    a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_IDLE)
        |=> !data_bus_line_oe)
        else $error("bus driven from idle");
    a_write_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (st.hst == HPO_H_WR_ACC)
        |-> !data_bus_line_oe)
        else $error("bus driven during a write");
endmodule : hpo_host_port

// [rtl/hpo_pkg.sv]
// Shared constants and types for the host port block
package hpo_pkg;
    localparam int HPO_NREG = 4;
    localparam int HPO_NCH = 4;
    localparam int HPO_NIRQ = 4;
    // APB byte offsets
    localparam logic [7:0] HPO_CTRL_OFF = 8'h00;
    localparam logic [7:0] HPO_SRD_OFF = 8'h04;
    localparam logic [7:0] HPO_STAT_OFF = 8'h08;
    localparam logic [7:0] HPO_LPCFG_OFF = 8'h0c;
    localparam logic [7:0] HPO_LPST_OFF = 8'h10;
    localparam logic [3:0] HPO_HREG_PAGE = 4'h2;
    // Control register fields and reset value
    localparam int HPO_CTRL_MODE_LSB = 0;
    localparam int HPO_CTRL_MUX_BIT = 2;
    localparam int HPO_CTRL_HW_BIT = 3;
    localparam logic [3:0] HPO_CTRL_RST = 4'h0;
    localparam logic [7:0] HPO_LPCFG_RST = 8'h00;
    // Serial frame: command byte then data byte, MSB first
    localparam logic [4:0] HPO_CMD_LAST = 5'h07;
    localparam logic [4:0] HPO_FRAME_LAST = 5'h0f;
    localparam logic [4:0] HPO_FRAME_DONE = 5'h10;
    localparam int HPO_CMD_RD_BIT = 7;

    typedef enum logic [1:0] {HPO_MODE_SERIAL, HPO_MODE_INTEL, HPO_MODE_MOTO, HPO_MODE_RSVD} hpo_mode_t;
    typedef enum logic [1:0] {HPO_LB_NONE, HPO_LB_REMOTE, HPO_LB_ANALOG} hpo_lb_t;
    typedef enum logic [1:0] {HPO_H_IDLE, HPO_H_RD_WAIT, HPO_H_RD_DRIVE, HPO_H_WR_ACC} hpo_hst_t;

    typedef struct packed {
        logic cs_n;
        logic strobe_n;
        logic dir;
        logic ale;
        logic [4:0] addr;
        logic [7:0] data;
    } hpo_par_pins_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] data;
    } hpo_ser_word_t;

    // Synchronised pin vector: toggle, loopback low, loopback high, parallel pins
    localparam int HPO_LO_LSB = 1;
    localparam int HPO_HI_LSB = HPO_LO_LSB + HPO_NCH;
    localparam int HPO_PAR_LSB = HPO_HI_LSB + HPO_NCH;
    localparam int HPO_PW = HPO_PAR_LSB + $bits(hpo_par_pins_t);
endpackage : hpo_pkg

// [rtl/hpo_serial_link.sv]
// Serial host link logic clocked by the shift clock
`timescale 1ns/1ns
module hpo_serial_link import hpo_pkg::*; (
    input wire logic sclk,
    input wire logic presetn,
    input wire logic frame_n,
    input wire logic serial_data_in,
    input wire logic output_edge_select,
    input wire logic [7:0] rd_data,
    output logic serial_data_out,
    output logic serial_data_oe,
    output hpo_ser_word_t wr_word,
    output logic wr_toggle
);
    typedef struct packed {
        logic [4:0] cnt;
        logic cmd_rd;
        logic [4:0] addr;
        logic [6:0] sh;
        logic [7:0] osr;
        logic oe;
    } hpo_frame_t;

    typedef struct packed {
        logic [2:0] edge_s;
        logic edge_q;
        logic [7:0] rd_s1;
        logic [7:0] rd_s2;
        logic [7:0] rd_s3;
        logic [7:0] rd_q;
        hpo_ser_word_t word;
        logic tog;
    } hpo_link_t;

    hpo_frame_t f;
    hpo_frame_t next_f;
    hpo_link_t l;
    hpo_link_t next_l;
    logic neg_bit;
    logic neg_oe;

    always_comb begin
        next_f = f;
        next_l = l;
        // Read data from the bus side is quasi-static; taken only once the word agrees
        next_l.edge_s = {l.edge_s[1:0], output_edge_select};
        if (l.edge_s[1] == l.edge_s[2]) begin
            next_l.edge_q = l.edge_s[2];
        end
        next_l.rd_s1 = rd_data;
        next_l.rd_s2 = l.rd_s1;
        next_l.rd_s3 = l.rd_s2;
        if (l.rd_s2 == l.rd_s3) begin
            next_l.rd_q = l.rd_s3;
        end
        if (f.cnt != HPO_FRAME_DONE) begin
            next_f.cnt = f.cnt + 5'h01;
            next_f.sh = {f.sh[5:0], serial_data_in};
        end
        if (f.cnt == HPO_CMD_LAST) begin
            next_f.cmd_rd = f.sh[HPO_CMD_RD_BIT - 1];
            next_f.addr = {f.sh[3:0], serial_data_in};
            next_f.osr = l.rd_q;
            next_f.oe = f.sh[HPO_CMD_RD_BIT - 1];
        end else if (f.cnt != HPO_FRAME_DONE && f.cnt > HPO_CMD_LAST) begin
            next_f.osr = {f.osr[6:0], 1'b0};
        end
        if (f.cnt == HPO_FRAME_LAST && !f.cmd_rd) begin
            next_l.word.addr = f.addr;
            next_l.word.data = {f.sh, serial_data_in};
            next_l.tog = ~l.tog;
        end
    end

    // Frame state restarts whenever the select is released
    always_ff @(posedge sclk or posedge frame_n) begin
        if (frame_n) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Half-cycle copy launches output on the falling edge
    always_ff @(negedge sclk or posedge frame_n) begin
        if (frame_n) begin
            neg_bit <= 1'b0;
            neg_oe <= 1'b0;
        end else begin
            neg_bit <= f.osr[7];
            neg_oe <= f.oe;
        end
    end

    assign serial_data_out = l.edge_q ? neg_bit : f.osr[7];
    assign serial_data_oe = l.edge_q ? neg_oe : f.oe;
    assign wr_word = l.word;
    assign wr_toggle = l.tog;

    a_write_float: assert property (@(posedge sclk) disable iff (frame_n)
        (f.cnt > HPO_CMD_LAST && !f.cmd_rd) |-> !f.oe && !neg_oe)
        else $error("output driven during serial write");
    a_cmd_float: assert property (@(posedge sclk) disable iff (frame_n)
        (f.cnt <= HPO_CMD_LAST) |-> !serial_data_oe ##1 (serial_data_oe == f.cmd_rd || l.edge_q))
        else $error("serial output enable wrong around command byte");
    a_edge_rise: assert property (@(posedge sclk) disable iff (frame_n)
        (!l.edge_q && f.cnt == HPO_CMD_LAST) |=> serial_data_out == l.rd_q[7] || !f.cmd_rd)
        else $error("rising-edge launch missed first data bit");
    a_cmd_capture: assert property (@(posedge sclk) disable iff (frame_n)
        (f.cnt == HPO_CMD_LAST) |=> f.addr == {$past(f.sh[3:0]), $past(serial_data_in)})
        else $error("command address not sampled on rising edge");
endmodule : hpo_serial_link

// [tb/hpo_host_model.sv]
// Serial host processor model for the shift-clock link
`timescale 1ns/1ns
module hpo_host_model (
    output logic sclk,
    output logic serial_cs_n,
    output logic serial_data_in,
    input wire logic output_edge_select,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    initial begin
        // Non-blocking so the frame logic sees the select rise at time zero
        serial_cs_n <= 1'b1;
        sclk <= 1'b0;
        serial_data_in <= 1'b0;
    end
    // Clock stands still between frames; 30 ns period inside them
    task automatic run_frame(input logic [15:0] bits, output logic [7:0] got, output int bad);
        int i;
        logic rd;
        rd = bits[15];
        got = 8'h00;
        bad = 0;
        serial_cs_n = 1'b0;
        for (i = 0; i < 16; i++) begin
            serial_data_in = bits[15-i];
            #14;
            if (serial_data_oe !== (rd && i >= 8)) bad++;
            if (output_edge_select && i >= 8) got = {got[6:0], serial_data_out};
            #1 sclk = 1'b1;
            #14;
            if (serial_data_oe !== (rd && i >= (output_edge_select ? 8 : 7))) bad++;
            if (!output_edge_select && i >= 7 && i < 15) got = {got[6:0], serial_data_out};
            #1 sclk = 1'b0;
        end
        #14;
        serial_cs_n = 1'b1;
        // Released line shows a changing value, never the last bit
        serial_data_in = ~serial_data_in;
        #16;
    endtask : run_frame
endmodule : hpo_host_model

// [tb/hpo_host_port_bench.sv]
// Self-checking bench for the host port block
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module hpo_host_port_bench import hpo_pkg::*; ;
    logic pclk = 1'b0;
    logic presetn;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk, serial_cs_n, serial_data_in, serial_data_out, serial_data_oe;
    logic output_edge_select = 1'b0;
    logic host_cs_n = 1'b1;
    logic host_strobe_n = 1'b1;
    logic host_dir = 1'b1;
    logic host_ale = 1'b0;
    logic [4:0] host_addr = 5'h00;
    logic [7:0] bus_drv = 8'h00;
    logic [7:0] data_bus_line_in, data_bus_line_out;
    logic data_bus_line_oe, ready_ack, interrupt_n_out, interrupt_n_oe;
    logic [HPO_NIRQ-1:0] irq_src = 4'h0;
    logic [HPO_NCH-1:0] loopback_select_lo = 4'h0;
    logic [HPO_NCH-1:0] loopback_select_hi = 4'h0;
    logic [2*HPO_NCH-1:0] loopback_mode;
    int fail_count = 0;
    int checks = 0;
    int seed = 32'had88;
    assign data_bus_line_in = data_bus_line_oe ? data_bus_line_out : bus_drv;
    always #10 pclk = ~pclk;
    hpo_host_port u_hpo_host_port (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .sclk, .serial_cs_n, .serial_data_in, .output_edge_select,
        .serial_data_out, .serial_data_oe, .host_cs_n, .host_strobe_n, .host_dir, .host_ale,
        .host_addr, .data_bus_line_in, .data_bus_line_out, .data_bus_line_oe, .ready_ack,
        .irq_src, .interrupt_n_out, .interrupt_n_oe, .loopback_select_lo, .loopback_select_hi,
        .loopback_mode);
    hpo_host_model u_hpo_host_model (.sclk, .serial_cs_n, .serial_data_in, .output_edge_select,
        .serial_data_out, .serial_data_oe);
    task automatic complete_run;
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic timeout;
        fail_count++;
        $display("CHECK FAILED %0t no answer", $time);
        complete_run();
    endtask : timeout
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) timeout();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic par(input logic moto, input logic mux, input logic rd, input logic [4:0] a,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        if (mux) begin
            host_ale <= 1'b1;
            bus_drv <= {3'b000, a};
            repeat (6) @(posedge pclk);
            host_ale <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        // In mux mode the separate address pins carry a wrong value on purpose
        host_addr <= mux ? ~a : a;
        bus_drv <= d;
        host_cs_n <= 1'b0;
        host_strobe_n <= ~(moto | rd);
        host_dir <= rd;
        for (n = 0; n < 40 && ready_ack !== 1'b0; n++) @(posedge pclk);
        for (; n < 40 && !moto && ready_ack !== 1'b1; n++) @(posedge pclk);
        if (n >= 40) timeout();
        `CHK(data_bus_line_oe, rd)
        q = data_bus_line_out;
        host_cs_n <= 1'b1;
        host_strobe_n <= 1'b1;
        host_dir <= 1'b1;
        bus_drv <= ~d;
        for (n = 0; n < 40 && (data_bus_line_oe !== 1'b0 || ready_ack !== 1'b1); n++) begin
            @(posedge pclk);
        end
        if (n >= 40) timeout();
        repeat (6) @(posedge pclk);
    endtask : par
    initial begin
        int i, c, cnt, bad, ex;
        int hreg[4];
        logic [31:0] r, v;
        logic e;
        logic [4:0] a;
        logic [7:0] d, q;
        cnt = 0;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, HPO_CTRL_OFF, 0, r, e);
        `CHK(r, 32'h0)
        apb(0, HPO_LPCFG_OFF, 0, r, e);
        `CHK(r, 32'h0)
        apb(0, 8'h40, 0, r, e);
        `CHK({e, r}, {1'b1, 32'h0})
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : $random(seed);
            irq_src <= v[3:0];
            repeat (3) @(posedge pclk);
            `CHK({interrupt_n_out, interrupt_n_oe}, {1'b0, |v[3:0]})
            apb(0, HPO_STAT_OFF, 0, r, e);
            `CHK(r[3:0], v[3:0])
        end
        // Board grounds the parallel lines while the serial host is in use
        bus_drv <= 8'h00;
        for (i = 0; i < 4; i++) begin
            a = i[4:0];
            d = $random(seed);
            output_edge_select <= i[0];
            @(posedge pclk);
            u_hpo_host_model.run_frame({3'b000, a, d}, q, bad);
            `CHK(bad, 0)
            hreg[i] = d;
            cnt++;
            repeat (10) @(posedge pclk);
            apb(0, HPO_STAT_OFF, 0, r, e);
            `CHK(r, {7'h0, a, d, cnt[7:0], v[3:0]})
            apb(0, 8'h20 + 8'(4 * i), 0, r, e);
            `CHK(r, {24'h0, d})
        end
        for (i = 0; i < 2; i++) begin
            d = $random(seed);
            apb(1, HPO_SRD_OFF, {24'h0, d}, r, e);
            output_edge_select <= ~i[0];
            @(posedge pclk);
            u_hpo_host_model.run_frame({8'h81, 8'h3c}, q, bad);
            `CHK(bad, 0)
            `CHK(q, d)
        end
        for (i = 0; i < 4; i++) begin
            apb(1, HPO_CTRL_OFF, {29'h0, i[0], i[1], ~i[1]}, r, e);
            a = 5'($random(seed) & 3);
            d = $random(seed);
            par(i[1], i[0], 1'b0, a, d, q);
            hreg[a] = d;
            par(i[1], i[0], 1'b1, a, 8'h00, q);
            `CHK(q, 8'(hreg[a]))
            apb(0, 8'h20 + 8'(4 * a), 0, r, e);
            `CHK(r, 32'(hreg[a][7:0]))
        end
        v = $random(seed);
        apb(1, HPO_LPCFG_OFF, v, r, e);
        apb(0, HPO_LPST_OFF, 0, r, e);
        `CHK(r, {24'h0, v[7:0]})
        apb(1, HPO_CTRL_OFF, 32'h8, r, e);
        // Upper lines rest at mid supply: neither comparator trips, so they read low
        bus_drv <= 8'h00;
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            loopback_select_lo <= v[3:0];
            loopback_select_hi <= v[7:4];
            repeat (8) @(posedge pclk);
            ex = 0;
            for (c = 0; c < HPO_NCH; c++) ex |= (v[c] ? 1 : (v[c+4] ? 2 : 0)) << (2 * c);
            `CHK(loopback_mode, 8'(ex))
            apb(0, HPO_LPST_OFF, 0, r, e);
            `CHK(r[7:0], 8'(ex))
        end
        complete_run();
    end
endmodule : hpo_host_port_bench
